// ===== logic/pll_core.sv
// Control core of a dual synthesizer: dividers, phase detectors, charge
// pump drive, power control, lock detection and the test output.
// Assumes synchronous pins and a plain register port from the host.
//
// Operation
// - Buffer output follows reference when enabled
// - Force pin keeps buffer output active
// - Reference divider makes comparison rate
// - Feedback divider, minimum value set by prescaler
// - Charge pump idle except error-width pulses
// - Aux current fixed, main sixteen steps
// - Main loop uses higher current while acquiring
// - Chip enable low powers both loops down
// - Enable high, bits clear: fully powered
// - Per-loop bit powers down its loop
// - Auto power-up on main divider write
// - Lock after five good consecutive comparisons
// - Locked: release when error exceeds hold
// - Windows 10/20 ns main, 15/30 aux
// - Powered-down loop forces lock output low
// - Optional divide-by-4 into lock detector
// - Combined lock low if either unlocked
//
// Local design decisions: the placing of the registers and strobed register access.
`timescale 1ns/1ns
module pll_core (
    input wire logic CORE_CLK,
    input wire logic RESET,
    input wire pll_pkg::reg_req_t REG_REQ,
    output logic [31:0] RDATA,
    input wire logic CE,
    input wire logic REF_IN,
    input wire logic BUFFER_FORCE_PIN,
    input wire logic [1:0] VCO_IN,
    output logic REFERENCE_BUFFER_OUTPUT,
    output pll_pkg::cp_out_t CP_MAIN,
    output pll_pkg::cp_out_t CP_AUX,
    output logic [3:0] CP_MAIN_CURRENT,
    output logic MAIN_POWERED,
    output logic AUX_POWERED,
    output logic TEST_LOCK_OUTPUT
);
    import pll_pkg::*;

    typedef struct packed {
        ctrl_t ctrl;
        logic [1:0][15:0] rdiv;
        logic [1:0][15:0] ndiv;
        logic [3:0] cp_norm;
        logic [3:0] cp_fast;
        logic [3:0] cp_cur;
        logic autopu;
        logic ref_prev;
        logic [1:0] vco_prev;
        logic [1:0][15:0] rcnt;
        logic [1:0][15:0] ncnt;
        pfd_state_t [1:0] pfd;
        logic [1:0][15:0] err;
        logic [1:0] meas;
        logic test_out;
        logic [31:0] rdata;
    } core_state_t;

    core_state_t s_reg;
    core_state_t s_next;
    logic [1:0] powered;
    logic [1:0] locked;
    logic [1:0] r_ev;
    logic [1:0] n_ev;
    logic [1:0][15:0] r_lim;
    logic [1:0][15:0] n_lim;
    logic ref_rise;
    logic autopu_set;
    logic wr_ctrl;

    ////////////////////////////////////////////////////////////////////////
    // Power and reference buffer; chip enable acts with no clock edge
    assign powered[0] = CE && (!s_reg.ctrl.main_loop_powerdown
        || s_reg.autopu);
    assign powered[1] = CE && !s_reg.ctrl.aux_loop_powerdown;
    assign MAIN_POWERED = powered[0];
    assign AUX_POWERED = powered[1];
    // A clock copy, so it cannot go through a flip-flop
    assign REFERENCE_BUFFER_OUTPUT = REF_IN
        && (s_reg.ctrl.buffer_output_enable_bit
        || BUFFER_FORCE_PIN);

    ////////////////////////////////////////////////////////////////////////
    // Dividers, phase detectors and registers
    always_comb begin
        s_next = s_reg;
        s_next.rdata = '0;
        s_next.meas = '0;
        s_next.ref_prev = REF_IN;
        s_next.vco_prev = VCO_IN;
        ref_rise = REF_IN && !s_reg.ref_prev;
        r_ev = '0;
        n_ev = '0;
        for (int i = 0; i < 2; i++) begin
            r_lim[i] = (s_reg.rdiv[i] == 16'h0000) ? 16'h0001 : s_reg.rdiv[i];
            // Prescaler cannot divide below its floor
            n_lim[i] = (s_reg.ndiv[i] < NDIV_MIN[i]) ? NDIV_MIN[i]
                : s_reg.ndiv[i];
            if (!powered[i]) begin
                s_next.rcnt[i] = '0;
                s_next.ncnt[i] = '0;
                s_next.pfd[i] = PFD_IDLE;
                s_next.err[i] = '0;
            end else begin
                if (ref_rise) begin
                    if (s_reg.rcnt[i] >= r_lim[i] - 16'h0001) begin
                        s_next.rcnt[i] = '0;
                        r_ev[i] = 1'b1;
                    end else begin
                        s_next.rcnt[i] = s_reg.rcnt[i] + 16'h0001;
                    end
                end
                if (VCO_IN[i] && !s_reg.vco_prev[i]) begin
                    if (s_reg.ncnt[i] >= n_lim[i] - 16'h0001) begin
                        s_next.ncnt[i] = '0;
                        n_ev[i] = 1'b1;
                    end else begin
                        s_next.ncnt[i] = s_reg.ncnt[i] + 16'h0001;
                    end
                end
                // Pulse width counts the phase error in core cycles
                case (s_reg.pfd[i])
                    PFD_IDLE: begin
                        if (r_ev[i] && n_ev[i]) begin
                            s_next.err[i] = '0;
                            s_next.meas[i] = 1'b1;
                        end else if (r_ev[i]) begin
                            s_next.pfd[i] = PFD_UP;
                            s_next.err[i] = 16'h0001;
                        end else if (n_ev[i]) begin
                            s_next.pfd[i] = PFD_DN;
                            s_next.err[i] = 16'h0001;
                        end
                    end
                    PFD_UP, PFD_DN: begin
                        if ((s_reg.pfd[i] == PFD_UP && n_ev[i])
                            || (s_reg.pfd[i] == PFD_DN && r_ev[i])) begin
                            s_next.pfd[i] = PFD_IDLE;
                            s_next.meas[i] = 1'b1;
                        end else if (s_reg.err[i] != 16'hFFFF) begin
                            s_next.err[i] = s_reg.err[i] + 16'h0001;
                        end
                    end
                    default: begin
                        s_next.pfd[i] = PFD_IDLE;
                    end
                endcase
            end
        end

        wr_ctrl = REG_REQ.wr && (REG_REQ.addr == OFS_CTRL);
        autopu_set = REG_REQ.wr && (REG_REQ.addr == OFS_MAIN_N) && CE
            && s_reg.ctrl.auto_powerup_on_write;
        if (REG_REQ.wr) begin
            case (REG_REQ.addr)
                OFS_CTRL: begin
                    s_next.ctrl.buffer_output_enable_bit =
                        REG_REQ.wdata[BUF_EN_BIT];
                    s_next.ctrl.main_loop_powerdown = REG_REQ.wdata[MAIN_PD_BIT];
                    s_next.ctrl.aux_loop_powerdown = REG_REQ.wdata[AUX_PD_BIT];
                    s_next.ctrl.auto_powerup_on_write =
                        REG_REQ.wdata[AUTOPU_BIT];
                    s_next.ctrl.lock_compare_divide = REG_REQ.wdata[LOCKDIV_BIT];
                    s_next.ctrl.test_output_select =
                        REG_REQ.wdata[TSEL_LSB +: 3];
                end
                OFS_MAIN_R: s_next.rdiv[0] = REG_REQ.wdata[15:0];
                OFS_MAIN_N: s_next.ndiv[0] = REG_REQ.wdata[15:0];
                OFS_AUX_R: s_next.rdiv[1] = REG_REQ.wdata[15:0];
                OFS_AUX_N: s_next.ndiv[1] = REG_REQ.wdata[15:0];
                OFS_CP: begin
                    s_next.cp_norm = REG_REQ.wdata[CP_NORM_LSB +: 4];
                    s_next.cp_fast = REG_REQ.wdata[CP_FAST_LSB +: 4];
                end
                default: begin
                end
            endcase
        end
        // A fresh control write hands power back to the power-down bit
        if (!CE || wr_ctrl) begin
            s_next.autopu = 1'b0;
        end
        if (autopu_set) begin
            s_next.autopu = 1'b1;
        end

        if (REG_REQ.rd) begin
            case (REG_REQ.addr)
                OFS_CTRL: begin
                    s_next.rdata[BUF_EN_BIT] =
                        s_reg.ctrl.buffer_output_enable_bit;
                    s_next.rdata[MAIN_PD_BIT] = s_reg.ctrl.main_loop_powerdown;
                    s_next.rdata[AUX_PD_BIT] = s_reg.ctrl.aux_loop_powerdown;
                    s_next.rdata[AUTOPU_BIT] = s_reg.ctrl.auto_powerup_on_write;
                    s_next.rdata[LOCKDIV_BIT] = s_reg.ctrl.lock_compare_divide;
                    s_next.rdata[TSEL_LSB +: 3] = s_reg.ctrl.test_output_select;
                end
                OFS_MAIN_R: s_next.rdata[15:0] = s_reg.rdiv[0];
                OFS_MAIN_N: s_next.rdata[15:0] = s_reg.ndiv[0];
                OFS_AUX_R: s_next.rdata[15:0] = s_reg.rdiv[1];
                OFS_AUX_N: s_next.rdata[15:0] = s_reg.ndiv[1];
                OFS_CP: begin
                    s_next.rdata[CP_NORM_LSB +: 4] = s_reg.cp_norm;
                    s_next.rdata[CP_FAST_LSB +: 4] = s_reg.cp_fast;
                end
                OFS_STATUS: begin
                    s_next.rdata[ST_MAIN_LOCK_BIT] = locked[0];
                    s_next.rdata[ST_AUX_LOCK_BIT] = locked[1];
                    s_next.rdata[ST_MAIN_PWR_BIT] = powered[0];
                    s_next.rdata[ST_AUX_PWR_BIT] = powered[1];
                end
                default: s_next.rdata = '0;
            endcase
        end

        // Fast-lock current until the main loop declares lock
        s_next.cp_cur = locked[0] ? s_reg.cp_norm : s_reg.cp_fast;

        case (s_reg.ctrl.test_output_select)
            TSEL_MAIN_LOCK: s_next.test_out = locked[0] && powered[0];
            TSEL_AUX_LOCK: s_next.test_out = locked[1] && powered[1];
            TSEL_BOTH_LOCK: s_next.test_out = &(locked & powered);
            default: s_next.test_out = 1'b0;
        endcase

        if (RESET) begin
            s_next = '0;
            s_next.rdiv = {R_DIV_RESET, R_DIV_RESET};
            s_next.ndiv = {N_DIV_RESET, N_DIV_RESET};
            s_next.cp_norm = CP_NORM_RESET;
            s_next.cp_fast = CP_FAST_RESET;
            s_next.cp_cur = CP_FAST_RESET;
            s_next.pfd = {PFD_IDLE, PFD_IDLE};
        end
    end

    always_ff @(posedge CORE_CLK) begin
        s_reg <= s_next;
    end

    ////////////////////////////////////////////////////////////////////////
    // Lock detectors, one per loop
    generate
        for (genvar g = 0; g < 2; g++) begin : g_lock
            lock_detector #(
                .ACQ_CYC(g == 0 ? ACQ_MAIN_CYC : ACQ_AUX_CYC),
                .HOLD_CYC(g == 0 ? HOLD_MAIN_CYC : HOLD_AUX_CYC)
            ) u_lock (
                .clk(CORE_CLK),
                .rst(RESET),
                .powered(powered[g]),
                .lock_compare_divide(s_reg.ctrl.lock_compare_divide),
                .meas_valid(s_reg.meas[g]),
                .err(s_reg.err[g]),
                .locked(locked[g])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Outputs; aux charge pump current is fixed, so it has no select
    // Power gates the pump at once; the detector state clears a cycle later
    assign CP_MAIN.up = powered[0] && (s_reg.pfd[0] == PFD_UP);
    assign CP_MAIN.dn = powered[0] && (s_reg.pfd[0] == PFD_DN);
    assign CP_MAIN.oe_n = !(CP_MAIN.up || CP_MAIN.dn);
    assign CP_AUX.up = powered[1] && (s_reg.pfd[1] == PFD_UP);
    assign CP_AUX.dn = powered[1] && (s_reg.pfd[1] == PFD_DN);
    assign CP_AUX.oe_n = !(CP_AUX.up || CP_AUX.dn);
    assign CP_MAIN_CURRENT = s_reg.cp_cur;
    assign TEST_LOCK_OUTPUT = s_reg.test_out;
    assign RDATA = s_reg.rdata;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    a_buf_enable: assert property (@(posedge CORE_CLK) disable iff (RESET)
        s_reg.ctrl.buffer_output_enable_bit |-> REFERENCE_BUFFER_OUTPUT == REF_IN)
        else $error("buffer output not following reference");
    a_buf_force: assert property (@(posedge CORE_CLK) disable iff (RESET)
        BUFFER_FORCE_PIN |-> REFERENCE_BUFFER_OUTPUT == REF_IN)
        else $error("force pin did not enable buffer");
    a_ce_powerdown: assert property (@(posedge CORE_CLK) disable iff (RESET)
        !CE |-> !MAIN_POWERED && !AUX_POWERED ##1 !s_reg.autopu)
        else $error("powered while chip enable low");
    a_full_powerup: assert property (@(posedge CORE_CLK) disable iff (RESET)
        (CE && !s_reg.ctrl.main_loop_powerdown
        && !s_reg.ctrl.aux_loop_powerdown) |-> MAIN_POWERED && AUX_POWERED)
        else $error("not fully powered");
    a_aux_powerdown: assert property (@(posedge CORE_CLK) disable iff (RESET)
        s_reg.ctrl.aux_loop_powerdown |-> !AUX_POWERED && !CP_AUX.up
        && !CP_AUX.dn)
        else $error("aux loop active while powered down");
    a_auto_powerup: assert property (@(posedge CORE_CLK) disable iff (RESET)
        (REG_REQ.wr && REG_REQ.addr == OFS_MAIN_N && CE
        && s_reg.ctrl.auto_powerup_on_write) ##1 CE |-> MAIN_POWERED)
        else $error("main loop not powered after divider write");
    a_cp_current: assert property (@(posedge CORE_CLK) disable iff (RESET)
        ##1 CP_MAIN_CURRENT == ($past(locked[0]) ? $past(s_reg.cp_norm)
        : $past(s_reg.cp_fast)))
        else $error("wrong main charge pump current");
    a_cp_pulse: assert property (@(posedge CORE_CLK) disable iff (RESET)
        $rose(CP_MAIN.up) |-> $past(r_ev[0]) && !CP_MAIN.oe_n)
        else $error("charge pump pulse without reference event");
    a_lock_out_low: assert property (@(posedge CORE_CLK) disable iff (RESET)
        (s_reg.ctrl.test_output_select == TSEL_MAIN_LOCK && !powered[0])
        |=> !TEST_LOCK_OUTPUT)
        else $error("lock output high while loop powered down");
    a_both_lock: assert property (@(posedge CORE_CLK) disable iff (RESET)
        (s_reg.ctrl.test_output_select == TSEL_BOTH_LOCK
        && !(locked[0] && locked[1])) |=> !TEST_LOCK_OUTPUT)
        else $error("combined lock high with a loop unlocked");
endmodule

// ===== logic/pll_pkg.sv
// Constants, register map and carrier types of the synthesizer control core.
// Assumes a single 100 MHz core clock and synchronous pin inputs.
package pll_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int ACQ_MAIN_NS = 10;
    localparam int HOLD_MAIN_NS = 20;
    localparam int ACQ_AUX_NS = 15;
    localparam int HOLD_AUX_NS = 30;
    // Windows are upper limits, so they round down, never below one cycle
    localparam logic [15:0] ACQ_MAIN_CYC = 16'((ACQ_MAIN_NS / CLK_PERIOD_NS)
        < 1 ? 1 : ACQ_MAIN_NS / CLK_PERIOD_NS);
    localparam logic [15:0] HOLD_MAIN_CYC = 16'((HOLD_MAIN_NS / CLK_PERIOD_NS)
        < 1 ? 1 : HOLD_MAIN_NS / CLK_PERIOD_NS);
    localparam logic [15:0] ACQ_AUX_CYC = 16'((ACQ_AUX_NS / CLK_PERIOD_NS)
        < 1 ? 1 : ACQ_AUX_NS / CLK_PERIOD_NS);
    localparam logic [15:0] HOLD_AUX_CYC = 16'((HOLD_AUX_NS / CLK_PERIOD_NS)
        < 1 ? 1 : HOLD_AUX_NS / CLK_PERIOD_NS);
    localparam logic [2:0] LOCK_CYCLES = 3'h5;
    localparam logic [1:0] LOCK_PRE_LAST = 2'h3;

    ////////////////////////////////////////////////////////////////////////
    // Register map (byte addresses)
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_MAIN_R = 8'h04;
    localparam logic [7:0] OFS_MAIN_N = 8'h08;
    localparam logic [7:0] OFS_AUX_R = 8'h0C;
    localparam logic [7:0] OFS_AUX_N = 8'h10;
    localparam logic [7:0] OFS_CP = 8'h14;
    localparam logic [7:0] OFS_STATUS = 8'h18;

    localparam int BUF_EN_BIT = 0;
    localparam int MAIN_PD_BIT = 1;
    localparam int AUX_PD_BIT = 2;
    localparam int AUTOPU_BIT = 3;
    localparam int LOCKDIV_BIT = 4;
    localparam int TSEL_LSB = 8;
    localparam int CP_NORM_LSB = 0;
    localparam int CP_FAST_LSB = 4;
    localparam int ST_MAIN_LOCK_BIT = 0;
    localparam int ST_AUX_LOCK_BIT = 1;
    localparam int ST_MAIN_PWR_BIT = 2;
    localparam int ST_AUX_PWR_BIT = 3;

    localparam logic [2:0] TSEL_LOW = 3'h0;
    localparam logic [2:0] TSEL_MAIN_LOCK = 3'h1;
    localparam logic [2:0] TSEL_AUX_LOCK = 3'h2;
    localparam logic [2:0] TSEL_BOTH_LOCK = 3'h3;

    // Reset values; index 0 of per-loop arrays is the main loop
    localparam logic [15:0] R_DIV_RESET = 16'h0001;
    localparam logic [15:0] N_DIV_RESET = 16'h0010;
    localparam logic [1:0][15:0] NDIV_MIN = {16'h0008, 16'h0010};
    localparam logic [3:0] CP_NORM_RESET = 4'h0;
    localparam logic [3:0] CP_FAST_RESET = 4'hF;

    ////////////////////////////////////////////////////////////////////////
    // Types
    typedef enum logic [1:0] {PFD_IDLE, PFD_UP, PFD_DN} pfd_state_t;

    typedef struct packed {
        logic [2:0] test_output_select;
        logic lock_compare_divide;
        logic auto_powerup_on_write;
        logic aux_loop_powerdown;
        logic main_loop_powerdown;
        logic buffer_output_enable_bit;
    } ctrl_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;

    typedef struct packed {
        logic up;
        logic dn;
        logic oe_n;
    } cp_out_t;

    typedef struct packed {
        logic [2:0] count;
        logic [1:0] pre;
        logic locked;
    } lock_state_t;

endpackage

// ===== logic/lock_detector.sv
// Digital lock detector for one loop, acquire and hold windows as parameters.
// Assumes one measurement pulse per comparison with the error in cycles.
`timescale 1ns/1ns
module lock_detector #(
    parameter logic [15:0] ACQ_CYC = 16'h0001,
    parameter logic [15:0] HOLD_CYC = 16'h0002
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic powered,
    input wire logic lock_compare_divide,
    input wire logic meas_valid,
    input wire logic [15:0] err,
    output logic locked
);
    import pll_pkg::*;

    lock_state_t s_reg;
    lock_state_t s_next;
    logic take;

    always_comb begin
        s_next = s_reg;
        take = 1'b0;
        if (rst || !powered) begin
            s_next = '0;
        end else if (meas_valid) begin
            // Only one comparison in four counts when dividing
            take = !lock_compare_divide || (s_reg.pre == LOCK_PRE_LAST);
            s_next.pre = s_reg.pre + 2'h1;
            if (take) begin
                if (!s_reg.locked) begin
                    if (err < ACQ_CYC) begin
                        if (s_reg.count == LOCK_CYCLES - 3'h1) begin
                            s_next.locked = 1'b1;
                            s_next.count = '0;
                        end else begin
                            s_next.count = s_reg.count + 3'h1;
                        end
                    end else begin
                        s_next.count = '0;
                    end
                end else if (err > HOLD_CYC) begin
                    s_next.locked = 1'b0;
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        s_reg <= s_next;
    end

    assign locked = s_reg.locked;

    a_lock_after_five: assert property (@(posedge clk) disable iff (rst)
        $rose(s_reg.locked) |-> $past(s_reg.count) == LOCK_CYCLES - 3'h1)
        else $error("lock rose without five good comparisons");
    a_unlock_hold_window: assert property (@(posedge clk) disable iff (rst)
        (powered && s_reg.locked && meas_valid && take && err > HOLD_CYC)
        |=> !s_reg.locked)
        else $error("lock held past hold window");
    a_count_restart: assert property (@(posedge clk) disable iff (rst)
        (!s_reg.locked && meas_valid && take && err >= ACQ_CYC)
        |=> s_reg.count == 3'h0 && !s_reg.locked)
        else $error("bad comparison did not restart count");
endmodule

// ===== verif/ref_vco_model.sv
// Reference oscillator and VCO stand-in for the synthesizer control core.
// Assumes run is held low while the core's dividers are cleared.
`timescale 1ns/1ns
module ref_vco_model (
    input wire logic clk,
    input wire logic run,
    input wire logic [2:0] lag,
    output logic ref_in,
    output logic [1:0] vco_in
);
    logic [4:0] t_reg;
    always_ff @(posedge clk) begin
        t_reg <= run ? t_reg + 5'h01 : 5'h00;
    end
    // Sixteen VCO edges per reference period, the main loop's smallest divide
    assign vco_in = {2{run & t_reg[0]}};
    // One-cycle reference pulse, lag cycles after the 16th edge
    assign ref_in = run & (5'(t_reg - 5'(lag)) == 5'h1F);
endmodule

// ===== verif/pll_core_bench.sv
// Self-checking bench for the synthesizer control core.
// Assumes the core and the oscillator model are compiled beside it.
`timescale 1ns/1ns
module pll_core_bench;
    import pll_pkg::*;
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    reg_req_t reg_req = '0;
    logic ce = 1'b1;
    logic force_pin = 1'b0;
    logic run = 1'b0;
    logic [2:0] lag = 3'h0;
    logic [31:0] rdata;
    logic ref_in, buf_out, main_pwr, aux_pwr, lock_out;
    logic [1:0] vco_in;
    logic [3:0] cp_cur;
    cp_out_t cp_main, cp_aux;
    logic [31:0] rnd;
    logic pend = 1'b0;
    logic [31:0] exp_q[$];
    int fails = 0;
    int num_checks = 0;
    int cycles = 0;

    always #5 core_clk = ~core_clk;

    pll_core i_pll_core (.CORE_CLK(core_clk), .RESET(reset),
        .REG_REQ(reg_req), .RDATA(rdata), .CE(ce), .REF_IN(ref_in),
        .BUFFER_FORCE_PIN(force_pin), .VCO_IN(vco_in),
        .REFERENCE_BUFFER_OUTPUT(buf_out), .CP_MAIN(cp_main),
        .CP_AUX(cp_aux), .CP_MAIN_CURRENT(cp_cur), .MAIN_POWERED(main_pwr),
        .AUX_POWERED(aux_pwr), .TEST_LOCK_OUTPUT(lock_out));
    ref_vco_model i_ref_vco_model (.clk(core_clk), .run(run), .lag(lag),
        .ref_in(ref_in), .vco_in(vco_in));

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] want);
        num_checks++;
        if (got !== want) begin
            fails++;
            $display("unexpected at %0t: got %h want %h", $time, got, want);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        reg_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge core_clk);
        reg_req <= '0;
    endtask
    // Expected read data is queued; the monitor compares it a cycle later
    task automatic rd(input logic [7:0] a, input logic [31:0] want);
        exp_q.push_back(want);
        @(posedge core_clk);
        reg_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge core_clk);
        reg_req <= '0;
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task automatic summarize;
        if (fails == 0 && num_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    always @(posedge core_clk) begin
        cycles++;
        if (pend) begin
            chk(rdata, exp_q.pop_front());
        end
        pend = reg_req.rd;
        chk({30'h0, cp_main.oe_n, cp_aux.oe_n},
            {30'h0, ~(cp_main.up | cp_main.dn), ~(cp_aux.up | cp_aux.dn)});
        chk({31'h0, aux_pwr | ~(cp_aux.up | cp_aux.dn)}, 32'h1);
        if (cycles > 6000) begin
            fails++;
            summarize();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    initial begin
        rnd = $urandom(96753);
        wt(16);
        reset <= 1'b0;
        wt(1);
        rd(OFS_CP, 32'h000000F0);
        rd(OFS_MAIN_N, 32'h00000010);
        rd(OFS_STATUS, 32'h0000000C);
        rd(8'h1C, 32'h00000000);
        rnd = $urandom();
        wr(OFS_CP, rnd);
        rd(OFS_CP, {24'h0, rnd[7:0]});
        chk({28'h0, cp_cur}, {28'h0, rnd[7:4]});
        run <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            wr(OFS_CTRL, {31'h0, i[0]});
            force_pin <= i[1];
            repeat (40) begin
                wt(1);
                chk({31'h0, buf_out},
                    {31'h0, ref_in & (i[0] | i[1])});
            end
        end
        wr(OFS_CTRL, 32'h00000300);
        wt(100);
        rd(OFS_STATUS, 32'h0000000F);
        chk({31'h0, lock_out}, 32'h1);
        chk({28'h0, cp_cur}, {28'h0, rnd[3:0]});
        // Error of two stays inside both hold windows, three only the aux one
        lag <= 3'h2;
        wt(200);
        rd(OFS_STATUS, 32'h0000000F);
        lag <= 3'h3;
        wt(200);
        rd(OFS_STATUS, 32'h0000000E);
        wt(2);
        chk({31'h0, lock_out}, 32'h0);
        wr(OFS_CTRL, 32'h00000200);
        wt(3);
        chk({31'h0, lock_out}, 32'h1);
        wr(OFS_CTRL, 32'h00000204);
        wt(3);
        chk({30'h0, main_pwr, aux_pwr}, 32'h2);
        chk({31'h0, lock_out}, 32'h0);
        wr(OFS_CTRL, 32'h0000000A);
        wt(1);
        chk({30'h0, main_pwr, aux_pwr}, 32'h1);
        wr(OFS_MAIN_N, 32'h00000010);
        wt(1);
        chk({30'h0, main_pwr, aux_pwr}, 32'h3);
        ce <= 1'b0;
        run <= 1'b0;
        lag <= 3'h0;
        wt(1);
        chk({30'h0, main_pwr, aux_pwr}, 32'h0);
        wr(OFS_CTRL, 32'h00000110);
        ce <= 1'b1;
        wt(1);
        run <= 1'b1;
        wt(300);
        rd(OFS_STATUS, 32'h0000000C);
        wt(700);
        rd(OFS_STATUS, 32'h0000000F);
        wt(3);
        summarize();
    end
endmodule
